// >>> rtl/isr_top.sv
// Audio serial port receive path, status flags and request logic on APB
`timescale 1ns/1ps
// Summary of operation
// - Audio arrives in 16-bit units, one or two per sample by length and channel width.
// - Moving a unit into the receive buffer sets the has-word flag.
// - Has-word flag holds while data waits, clears on data register read.
// - Transmit-empty flag is high exactly while the send buffer is empty.
// - Unit arriving while has-word is set raises overflow; later data dropped.
// - Overflow clears by data register read then status register read.
// - Slave transmit word start with empty buffer raises underflow; status read clears.
// - Channel flag updates when transmit-empty or has-word flag sets.
// - In slave mode channel flag follows the external word-select line.
// - Word-select high is reported as the left channel.
// - Channel flag is meaningless in PCM format.
// - Busy rises at transfer start, hardware clears it; writes ignored.
// - Busy stays zero in master receive, when disabled or finished.
// - Busy drops one bit clock between consecutive words.
// - Each flag is gated by its own enable; errors share one.
// - DMA requests follow the flags as in SPI, without CRC.
module isr_top
  import isr_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              i2s_sck,
  input  wire logic              i2s_ws,
  input  wire logic              i2s_sd_in,
  output logic                   i2s_sd_out,
  output logic                   i2s_sd_oe,
  output logic                   irq,
  output logic                   tx_dma_req,
  output logic                   rx_dma_req
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  logic [CTL_W-1:0]  ctrl_reg;
  logic [CFG_W-1:0]  cfg_reg;
  logic [UNIT_W-1:0] rx_buf_reg;
  logic [UNIT_W-1:0] rx_sh_reg;
  logic [UNIT_W-1:0] tx_buf_reg;
  logic [UNIT_W-1:0] tx_sh_reg;
  logic              rx_has_word_flag;
  logic              tx_full_reg;
  logic              over_reg;
  logic              over_arm_reg;
  logic              under_reg;
  logic              lr_channel_flag;
  logic              busy_reg;
  logic [CNT_W-1:0]  bit_cnt_reg;
  logic              ws_prev_reg;
  logic              start_dly_reg;
  logic              word_ws_reg;
  logic              tx_ws_prev_reg;
  logic              tx_dly_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              sd_out_reg;
  logic              sd_oe_reg;
  logic              irq_reg;
  logic              tx_dma_reg;
  logic              rx_dma_reg;
  isr_lnk_t          lnk_reg;
  isr_lnk_t          lnk_next;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  wire       port_enable         = cfg_reg[CFG_EN];
  wire [1:0] role_direction_field = cfg_reg[CFG_ROLE_HI:CFG_ROLE_LO];
  wire [1:0] format_select       = cfg_reg[CFG_FMT_HI:CFG_FMT_LO];
  wire [1:0] sample_length_field = cfg_reg[CFG_LEN_HI:CFG_LEN_LO];
  wire       channel_width_bit   = cfg_reg[CFG_CHW];
  wire       tx_irq_enable       = ctrl_reg[CTL_TX_IE];
  wire       rx_irq_enable       = ctrl_reg[CTL_RX_IE];
  wire       error_irq_enable    = ctrl_reg[CTL_ERR_IE];
  wire       rx_mode   = (role_direction_field == ROLE_SLV_RX)
                       | (role_direction_field == ROLE_MST_RX);
  wire       slv_tx    = (role_direction_field == ROLE_SLV_TX);
  wire       mst_rx    = (role_direction_field == ROLE_MST_RX);
  wire       fmt_i2s   = (format_select == FMT_I2S);
  wire       tx_empty_flag = ~tx_full_reg;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable & pready_reg;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_sts  = (paddr == OFS_STS);
  wire hit_dat  = (paddr == OFS_DAT);
  wire hit_cfg  = (paddr == OFS_CFG);
  wire mapped   = hit_ctrl | hit_sts | hit_dat | hit_cfg;
  wire wr_ctrl  = access & pwrite & hit_ctrl;
  wire wr_cfg   = access & pwrite & hit_cfg;
  wire wr_dat   = access & pwrite & hit_dat;
  wire rd_dat   = access & ~pwrite & hit_dat;
  wire rd_sts   = access & ~pwrite & hit_sts;

  logic [CTL_W-1:0] sts_view;
  always_comb begin
    sts_view            = '0;
    sts_view[STS_BUSY]  = busy_reg;
    sts_view[STS_OVER]  = over_reg;
    sts_view[STS_UNDER] = under_reg;
    sts_view[STS_SIDE]  = lr_channel_flag;
    sts_view[STS_TXE]   = tx_empty_flag;
    sts_view[STS_RXF]   = rx_has_word_flag;
  end

  wire [DATA_W-1:0] rd_mux =
      hit_ctrl ? {{(DATA_W-CTL_W){1'b0}}, ctrl_reg} :
      hit_sts  ? {{(DATA_W-CTL_W){1'b0}}, sts_view} :
      hit_dat  ? {{(DATA_W-UNIT_W){1'b0}}, rx_buf_reg} :
      hit_cfg  ? {{(DATA_W-CFG_W){1'b0}}, cfg_reg} : '0;

  //////////////////////////////////////////////////////////////////////////////
  // Link sampling
  logic samp;
  logic drive;
  logic ws_lvl;
  logic sd_lvl;

  isr_link u_link (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_pol     (cfg_reg[CFG_CLKPOL]),
    .sck_pin     (i2s_sck),
    .ws_pin      (i2s_ws),
    .sd_pin      (i2s_sd_in),
    .samp_pulse  (samp),
    .drive_pulse (drive),
    .ws_level    (ws_lvl),
    .sd_level    (sd_lvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Receive framing
  wire              linked   = (lnk_reg != LNK_IDLE);
  wire              running  = (lnk_reg == LNK_RUN);
  wire              ws_chg   = (ws_lvl != ws_prev_reg);
  // Justified formats start on the select edge, I2S one bit later
  wire              word_go  = fmt_i2s ? start_dly_reg : ws_chg;
  wire [CNT_W-1:0]  cur_idx  = word_go ? '0 : bit_cnt_reg;
  wire [CNT_W-1:0]  cnt_inc  = (bit_cnt_reg == CNT_PARKED) ? CNT_PARKED
                                                           : bit_cnt_reg + CNT_ONE;
  wire [1:0]        unit_no  = cur_idx[CNT_W-1:CNT_W-2];
  wire              unit_end = (cur_idx[3:0] == UNIT_LAST);
  wire              late_16  = (sample_length_field == LEN_16) & channel_width_bit
                             & (format_select == FMT_LSB);
  wire              two_unit = (sample_length_field != LEN_16) & channel_width_bit;
  // LSB-justified short data sits in the second half of a wide channel
  wire              take_unit = late_16  ? (unit_no == UNIT_SECOND) :
                                two_unit ? (unit_no <= UNIT_SECOND)
                                         : (unit_no == UNIT_FIRST);
  wire [CNT_W-1:0]  last_bit = channel_width_bit ? LAST_BIT_32 : LAST_BIT_16;
  wire [UNIT_W-1:0] rx_sh_next = {rx_sh_reg[UNIT_W-2:0], sd_lvl};
  wire              push     = samp & linked & rx_mode & unit_end & take_unit;
  wire              rx_load  = push & ~over_reg & (~rx_has_word_flag | rd_dat);
  wire              over_set = push & ~over_reg & rx_has_word_flag & ~rd_dat;
  wire              side_now = ws_lvl ? CHAN_LEFT : CHAN_RIGHT;

  //////////////////////////////////////////////////////////////////////////////
  // Transmit framing
  wire tx_chg   = (ws_lvl != tx_ws_prev_reg);
  wire tx_go    = drive & linked & ~rx_mode & (fmt_i2s ? tx_dly_reg : tx_chg);
  wire tx_load  = tx_go & tx_full_reg;
  wire under_set = tx_go & ~tx_full_reg & slv_tx;

  //////////////////////////////////////////////////////////////////////////////
  // Link sequencer
  always_comb begin
    lnk_next = lnk_reg;
    unique case (lnk_reg)
      LNK_IDLE:  if (port_enable) lnk_next = LNK_ALIGN;
      // Fresh enable waits for a select edge before any data counts
      LNK_ALIGN: if (!port_enable) lnk_next = LNK_IDLE;
                 else if (samp & word_go) lnk_next = LNK_RUN;
      LNK_RUN:   if (!port_enable) lnk_next = LNK_IDLE;
      default:   lnk_next = LNK_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk_reg <= LNK_IDLE;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg   <= CNT_PARKED;
      ws_prev_reg   <= 1'b0;
      start_dly_reg <= 1'b0;
      word_ws_reg   <= 1'b0;
      rx_sh_reg     <= '0;
    end else if (!linked) begin
      bit_cnt_reg   <= CNT_PARKED;
      ws_prev_reg   <= ws_lvl;
      start_dly_reg <= 1'b0;
    end else if (samp) begin
      ws_prev_reg   <= ws_lvl;
      start_dly_reg <= ws_chg;
      bit_cnt_reg   <= word_go ? CNT_ONE : cnt_inc;
      rx_sh_reg     <= rx_sh_next;
      if (word_go) word_ws_reg <= ws_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive buffer and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_reg <= '0;
    end else if (rx_load) begin
      rx_buf_reg <= rx_sh_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_has_word_flag <= 1'b0;
    end else begin
      rx_has_word_flag <= rx_load | (rx_has_word_flag & ~rd_dat);
    end
  end

  // Overflow clears only on data read followed by status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_reg     <= 1'b0;
      over_arm_reg <= 1'b0;
    end else begin
      if (over_set) begin
        over_reg     <= 1'b1;
        over_arm_reg <= 1'b0;
      end else if (rd_sts & over_arm_reg) begin
        over_reg     <= 1'b0;
        over_arm_reg <= 1'b0;
      end else if (rd_dat & over_reg) begin
        over_arm_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      under_reg <= 1'b0;
    end else begin
      under_reg <= under_set | (under_reg & ~rd_sts);
    end
  end

  // Channel flag is simply latched in PCM too, where it carries no meaning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lr_channel_flag <= 1'b0;
    end else if (rx_load) begin
      lr_channel_flag <= word_ws_reg ? CHAN_LEFT : CHAN_RIGHT;
    end else if (tx_load) begin
      lr_channel_flag <= side_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Busy: low for the last bit clock of each channel slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
    end else if (!port_enable || !running || mst_rx) begin
      busy_reg <= 1'b0;
    end else if (samp) begin
      busy_reg <= (cur_idx != last_bit);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_reg  <= '0;
      tx_full_reg <= 1'b0;
    end else begin
      if (wr_dat) tx_buf_reg <= pwdata[UNIT_W-1:0];
      tx_full_reg <= wr_dat | (tx_full_reg & ~tx_load);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ws_prev_reg <= 1'b0;
      tx_dly_reg     <= 1'b0;
      tx_sh_reg      <= '0;
      sd_out_reg     <= 1'b0;
    end else if (!linked) begin
      tx_ws_prev_reg <= ws_lvl;
      tx_dly_reg     <= 1'b0;
      sd_out_reg     <= 1'b0;
    end else if (drive) begin
      tx_ws_prev_reg <= ws_lvl;
      tx_dly_reg     <= tx_chg;
      if (tx_load) begin
        sd_out_reg <= tx_buf_reg[UNIT_W-1];
        tx_sh_reg  <= {tx_buf_reg[UNIT_W-2:0], 1'b0};
      end else begin
        // An underrun shifts out zeros for the missed word
        sd_out_reg <= tx_sh_reg[UNIT_W-1];
        tx_sh_reg  <= {tx_sh_reg[UNIT_W-2:0], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes and APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTL_RST;
      cfg_reg  <= CFG_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= pwdata[CTL_W-1:0] & CTL_WMASK;
      if (wr_cfg)  cfg_reg  <= pwdata[CFG_W-1:0] & CFG_WMASK;
    end
  end

  // Status writes have no decode: busy and flags are hardware only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= 1'b1;
      pslverr_reg <= psel & ~mapped;
      if (setup) prdata_reg <= pwrite ? '0 : rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Requests: one cycle behind the flags they follow
  wire irq_next = (tx_empty_flag & tx_irq_enable)
                | (rx_has_word_flag & rx_irq_enable)
                | ((under_reg | over_reg) & error_irq_enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg    <= 1'b0;
      tx_dma_reg <= 1'b0;
      rx_dma_reg <= 1'b0;
      sd_oe_reg  <= 1'b0;
    end else begin
      irq_reg    <= irq_next;
      tx_dma_reg <= tx_empty_flag & ctrl_reg[CTL_TDMA] & port_enable & ~rx_mode;
      rx_dma_reg <= rx_has_word_flag & ctrl_reg[CTL_RDMA];
      sd_oe_reg  <= port_enable & ~rx_mode;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign i2s_sd_out = sd_out_reg;
  assign i2s_sd_oe  = sd_oe_reg;
  assign irq        = irq_reg;
  assign tx_dma_req = tx_dma_reg;
  assign rx_dma_req = rx_dma_reg;

endmodule

// >>> rtl/isr_pkg.sv
// Shared constants and types of the audio serial receive and status block
package isr_pkg;

  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned UNIT_W      = 16;
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned SYNC_STAGES = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DAT  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CFG  = 8'h1c;

  // Control register fields
  localparam int unsigned CTL_TX_IE  = 7;
  localparam int unsigned CTL_RX_IE  = 6;
  localparam int unsigned CTL_ERR_IE = 5;
  localparam int unsigned CTL_TDMA   = 1;
  localparam int unsigned CTL_RDMA   = 0;
  localparam int unsigned CTL_W      = 8;
  localparam logic [CTL_W-1:0] CTL_WMASK = 8'he3;
  localparam logic [CTL_W-1:0] CTL_RST   = 8'h00;

  // Status register fields
  localparam int unsigned STS_BUSY  = 7;
  localparam int unsigned STS_OVER  = 6;
  localparam int unsigned STS_UNDER = 3;
  localparam int unsigned STS_SIDE  = 2;
  localparam int unsigned STS_TXE   = 1;
  localparam int unsigned STS_RXF   = 0;

  // Configuration register fields
  localparam int unsigned CFG_W       = 12;
  localparam int unsigned CFG_MODESEL = 11;
  localparam int unsigned CFG_EN      = 10;
  localparam int unsigned CFG_ROLE_HI = 9;
  localparam int unsigned CFG_ROLE_LO = 8;
  localparam int unsigned CFG_FMT_HI  = 5;
  localparam int unsigned CFG_FMT_LO  = 4;
  localparam int unsigned CFG_CLKPOL  = 3;
  localparam int unsigned CFG_LEN_HI  = 2;
  localparam int unsigned CFG_LEN_LO  = 1;
  localparam int unsigned CFG_CHW     = 0;
  localparam logic [CFG_W-1:0] CFG_WMASK = 12'hf3f;
  localparam logic [CFG_W-1:0] CFG_RST   = 12'h000;

  localparam logic [1:0]       LEN_16      = 2'b00;
  localparam logic [3:0]       UNIT_LAST   = 4'hf;
  localparam logic [CNT_W-1:0] CNT_PARKED  = 6'h3f;
  localparam logic [CNT_W-1:0] LAST_BIT_16 = 6'h0f;
  localparam logic [CNT_W-1:0] LAST_BIT_32 = 6'h1f;
  localparam logic [CNT_W-1:0] CNT_ONE     = 6'h01;
  localparam logic [1:0]       UNIT_FIRST  = 2'b00;
  localparam logic [1:0]       UNIT_SECOND = 2'b01;

  localparam logic CHAN_LEFT  = 1'b0;
  localparam logic CHAN_RIGHT = 1'b1;

  typedef enum logic [1:0] {
    ROLE_SLV_TX = 2'b00,
    ROLE_SLV_RX = 2'b01,
    ROLE_MST_TX = 2'b10,
    ROLE_MST_RX = 2'b11
  } isr_role_t;

  typedef enum logic [1:0] {
    FMT_I2S = 2'b00,
    FMT_MSB = 2'b01,
    FMT_LSB = 2'b10,
    FMT_PCM = 2'b11
  } isr_fmt_t;

  typedef enum logic [1:0] {
    LNK_IDLE  = 2'b00,
    LNK_ALIGN = 2'b01,
    LNK_RUN   = 2'b10
  } isr_lnk_t;

endpackage

// >>> rtl/isr_link.sv
// Pin synchroniser and bit-clock edge finder for the audio serial lines
`timescale 1ns/1ps
module isr_link
  import isr_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_pol,
  input  wire logic sck_pin,
  input  wire logic ws_pin,
  input  wire logic sd_pin,
  output logic      samp_pulse,
  output logic      drive_pulse,
  output logic      ws_level,
  output logic      sd_level
);

  logic [2:0] pins;
  logic [2:0] lvl;
  logic [2:0] agree;
  logic [2:0] filt_reg;
  logic       sck_rise;
  logic       sck_fall;

  assign pins = {sd_pin, ws_pin, sck_pin};

  //////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic [SYNC_STAGES-1:0] sync_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_reg <= '0;
        end else begin
          sync_reg <= {sync_reg[SYNC_STAGES-2:0], pins[g]};
        end
      end
      // Stage one feeds stage two only; a level counts once two and three agree
      assign agree[g] = (sync_reg[1] == sync_reg[2]);
      assign lvl[g]   = sync_reg[2];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_reg[g] <= 1'b0;
        end else if (agree[g]) begin
          filt_reg[g] <= lvl[g];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  assign sck_rise    = agree[0] & lvl[0] & ~filt_reg[0];
  assign sck_fall    = agree[0] & ~lvl[0] & filt_reg[0];
  assign samp_pulse  = clk_pol ? sck_fall : sck_rise;
  assign drive_pulse = clk_pol ? sck_rise : sck_fall;
  // Select taken as soon as it settles, so a drive edge sees the change it arrives with
  assign ws_level    = agree[1] ? lvl[1] : filt_reg[1];
  assign sd_level    = filt_reg[2];

endmodule

// >>> verification/isr_top_assertions.sv
// Port-level assertions for the audio serial status block
`timescale 1ns/1ps
module isr_top_assertions
  import isr_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq,
  input wire logic              rx_dma_req,
  input wire logic              tx_dma_req
);
  logic [CTL_W-1:0] ctl_sh;
  logic [CFG_W-1:0] cfg_sh;
  wire acc = psel && penable && pready;
  wire mapped = paddr == OFS_CTRL || paddr == OFS_STS || paddr == OFS_DAT || paddr == OFS_CFG;
  wire sts_rd = acc && !pwrite && paddr == OFS_STS;
  wire rx_seen = sts_rd && prdata[STS_RXF];
  wire tx_seen = sts_rd && prdata[STS_TXE] && ctl_sh[CTL_TDMA];
  wire tx_role = cfg_sh[CFG_EN] && !cfg_sh[CFG_ROLE_LO];
  wire err_on = (prdata[STS_OVER] || prdata[STS_UNDER]) && ctl_sh[CTL_ERR_IE];
  wire quiet = !cfg_sh[CFG_EN] || cfg_sh[CFG_ROLE_HI:CFG_ROLE_LO] == 2'b11;

  ////////////////////////////////////////////////////////////////////////////
  // Shadows tie flag reads to their enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_sh <= CTL_RST;
      cfg_sh <= CFG_RST;
    end else if (acc && pwrite && paddr == OFS_CTRL) begin
      ctl_sh <= pwdata[CTL_W-1:0] & CTL_WMASK;
    end else if (acc && pwrite && paddr == OFS_CFG) begin
      cfg_sh <= pwdata[CFG_W-1:0] & CFG_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY_HIGH: assert property ($past(presetn) |-> pready)
    else $error("pready low");
  AST_SLVERR_UNMAPPED: assert property (acc && !mapped |-> pslverr)
    else $error("no slave error");
  AST_SLVERR_MAPPED: assert property (acc && mapped |-> !pslverr)
    else $error("spurious slave error");
  AST_UNMAPPED_ZERO: assert property (acc && !pwrite && !mapped |-> prdata == '0)
    else $error("unmapped read not zero");
  AST_NO_CRC_BIT: assert property (sts_rd |-> prdata[31:8] == '0 && prdata[5:4] == 2'b00)
    else $error("status reserved bits set");
  AST_IRQ_RX: assert property (rx_seen && ctl_sh[CTL_RX_IE] |-> ##[0:1] irq)
    else $error("rx irq missing");
  AST_IRQ_ERR: assert property (sts_rd && err_on |-> ##[0:1] irq)
    else $error("error irq missing");
  AST_RX_DMA: assert property (rx_seen && ctl_sh[CTL_RDMA] |-> ##[0:1] rx_dma_req)
    else $error("rx dma missing");
  AST_TX_DMA: assert property (tx_seen && tx_role |-> ##[0:1] tx_dma_req)
    else $error("tx dma missing");
  AST_BUSY_LOW: assert property (sts_rd && quiet |-> !prdata[STS_BUSY])
    else $error("busy while quiet");
  COV_OVER: cover property (sts_rd && prdata[STS_OVER]);
  COV_UNDER: cover property (sts_rd && prdata[STS_UNDER]);
  COV_RX: cover property (sts_rd && prdata[STS_RXF]);
endmodule

bind isr_top isr_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .rx_dma_req(rx_dma_req),
  .tx_dma_req(tx_dma_req));

// >>> verification/isr_codec_model.sv
// Behavioural external audio master: bit clock, word select, data
`timescale 1ns/1ps
module isr_codec_model (
  input  wire logic        run,
  input  wire logic        wide,
  input  wire logic        just,
  input  wire logic [15:0] word,
  output logic             sck,
  output logic             ws,
  output logic             sd
);
  logic [5:0] slot_bit;
  logic       sd_next;
  logic       bit_now;
  initial begin
    sck = 1'b0;
    ws = 1'b0;
    sd = 1'b0;
    slot_bit = 6'h00;
    sd_next = 1'b0;
    bit_now = 1'b0;
  end
  // Clock parks low while run is low; data line not held then
  // Wide channels repeat the word twice; justified puts the MSB on the select edge
  always begin
    #80;
    if (run || sck) begin
      sck = ~sck;
      if (!sck) begin
        ws = !(wide ? slot_bit[5] : slot_bit[4]);
        bit_now = word[~slot_bit[3:0]] ^ !ws;
        sd = just ? bit_now : sd_next;
        sd_next = bit_now;
        slot_bit = wide ? slot_bit + 6'h01 : {1'b0, slot_bit[4:0] + 5'h01};
      end
    end else begin
      sd = ~sd;
    end
  end
endmodule

// >>> verification/tb.sv
// Self-checking bench: APB register tests against a behavioural codec
`timescale 1ns/1ps
module tb
  import isr_pkg::*;
;
  localparam logic [15:0] PAT = 16'hc3a5;
  logic              pclk, presetn, psel, penable, pwrite, run, wide, just;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd, st;
  logic              pready, pslverr, sck, ws, sd, sd_oe, sd_o, irq;
  int                error_cnt, compares;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  isr_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i2s_sck(sck), .i2s_ws(ws), .i2s_sd_in(sd), .i2s_sd_out(sd_o),
    .i2s_sd_oe(sd_oe), .irq(irq), .tx_dma_req(), .rx_dma_req());
  isr_codec_model CODEC (.run(run), .wide(wide), .just(just), .word(PAT), .sck(sck),
    .ws(ws), .sd(sd));

  task automatic summarize();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    @(posedge pclk);
  endtask

  // Polls status until one bit is seen set
  task automatic wait_sts(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STS, '0);
      n++;
    end while (rd[b] !== 1'b1 && n < 1000);
    if (rd[b] !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask

  // Master receive in wide channels, then the stop delay the format asks for
  task automatic mrx_wide(input logic [31:0] cfg, input int stop);
    apb(1'b1, OFS_CFG, cfg);
    run <= 1'b1;
    wait_sts(STS_RXF);
    st = rd;
    apb(1'b0, OFS_DAT, '0);
    chk({16'h0000, rd[15:0]}, {16'h0000, st[STS_SIDE] ? ~PAT : PAT});
    repeat (stop) @(posedge pclk);
    apb(1'b1, OFS_CFG, '0);
    run <= 1'b0;
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, run, wide, just} = 6'h00;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, OFS_STS, '0);
    chk(rd, 32'h0000_0002);
    apb(1'b1, OFS_STS, 32'h0000_00ff);
    apb(1'b0, OFS_STS, '0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 8'h10, '0);
    chk(rd, '0);
    $display("test reset done");
    apb(1'b1, OFS_CTRL, 32'h0000_0061);
    apb(1'b1, OFS_CFG, 32'h0000_0500);
    run <= 1'b1;
    wait_sts(STS_BUSY);
    wait_sts(STS_RXF);
    st = rd;
    apb(1'b0, OFS_DAT, '0);
    chk({16'h0000, rd[15:0]}, {16'h0000, st[STS_SIDE] ? ~PAT : PAT});
    apb(1'b0, OFS_STS, '0);
    chk(32'(rd[STS_RXF]), 32'h0000_0000);
    wait_sts(STS_RXF);
    st = rd;
    wait_sts(STS_OVER);
    apb(1'b0, OFS_STS, '0);
    chk(32'(rd[STS_OVER]), 32'h0000_0001);
    apb(1'b0, OFS_DAT, '0);
    chk({16'h0000, rd[15:0]}, {16'h0000, st[STS_SIDE] ? ~PAT : PAT});
    apb(1'b0, OFS_STS, '0);
    apb(1'b0, OFS_STS, '0);
    chk(32'(rd[STS_OVER]), 32'h0000_0000);
    wait_sts(STS_RXF);
    apb(1'b1, OFS_CFG, '0);
    run <= 1'b0;
    apb(1'b0, OFS_DAT, '0);
    $display("test slave receive done");
    apb(1'b1, OFS_CFG, 32'h0000_0700);
    run <= 1'b1;
    repeat (40) begin
      apb(1'b0, OFS_STS, '0);
      chk(32'(rd[STS_BUSY]), 32'h0000_0000);
    end
    wait_sts(STS_RXF);
    st = rd;
    apb(1'b0, OFS_DAT, '0);
    chk({16'h0000, rd[15:0]}, {16'h0000, st[STS_SIDE] ? ~PAT : PAT});
    repeat (16) @(posedge pclk);
    apb(1'b1, OFS_CFG, '0);
    run <= 1'b0;
    wide <= 1'b1;
    just <= 1'b1;
    mrx_wide(32'h0000_0711, 16);
    mrx_wide(32'h0000_0721, 272);
    wide <= 1'b0;
    just <= 1'b0;
    $display("test master receive done");
    apb(1'b1, OFS_CTRL, 32'h0000_0022);
    apb(1'b1, OFS_DAT, 32'h0000_9234);
    apb(1'b0, OFS_STS, '0);
    chk(32'(rd[STS_TXE]), 32'h0000_0000);
    apb(1'b1, OFS_CFG, 32'h0000_0400);
    run <= 1'b1;
    wait_sts(STS_TXE);
    chk(32'(sd_oe), 32'h0000_0001);
    chk(32'(sd_o), 32'h0000_0001);
    wait_sts(STS_UNDER);
    apb(1'b0, OFS_STS, '0);
    chk(32'(rd[STS_UNDER]), 32'h0000_0000);
    $display("test slave transmit done");
    summarize();
  end
endmodule
